// [logic/acr_accel_ctrl.sv]
// Accelerometer control register bank: power/rate/axis and reload/filter
// control, reference value and filter-zero location.
// Assumes the serial interface hands over one decoded access per cycle.
//
// Operation
// (RQ1) Registers selected by seven-bit register address.
// (RQ2) Answer target address 001100x, x from pin.
// (RQ3) Power mode resets to power-down.
// (RQ4) Code 001 normal; 010-110 low-power rates.
// (RQ5) Rate field picks 50/100/400/1000 Hz.
// (RQ6) Rate field also sets low-pass cut-off.
// (RQ7) Axis enables reset to one each.
// (RQ8) Reload bit copies flash trim into registers.
// (RQ9) Reload bit self-clears when copy finishes.
// (RQ10) Trim copied automatically at power-up.
// (RQ11) High-pass mode 00/10 normal, 01 reference.
// (RQ12) Filtered-data select routes filter to output.
// (RQ13) Second interrupt generator filter enable bit.
// (RQ14) First interrupt generator filter enable bit.
// (RQ15) Coefficient field selects 8, 16, 32, 64.
// (RQ16) High-pass cut-off scales with rate, halves.
// (RQ17) Reading zero location clears filter state.
// (RQ18) Reference mode filters against reference register.
// (RQ19) Power 111 is power-down; mode 11 normal.
// (RQ20) Mode and rate changes apply at boundaries.
`timescale 1ns/10ps
`default_nettype none
`include "acr_defs.svh"
module acr_accel_ctrl
#(
    parameter int TRIM_AW = 3,
    parameter int TRIM_W  = 8,
    parameter logic [8:0][31:0] PERIODS = {
        32'(`ACR_CYC_LP4), 32'(`ACR_CYC_LP3), 32'(`ACR_CYC_LP2),
        32'(`ACR_CYC_LP1), 32'(`ACR_CYC_LP0), 32'(`ACR_CYC_ODR3),
        32'(`ACR_CYC_ODR2), 32'(`ACR_CYC_ODR1), 32'(`ACR_CYC_ODR0)}
)
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire acr_pkg::acr_access_t acc,
    input  wire logic               addr_sel,
    output logic [7:0]              rdata_q,
    output logic                    rvalid_q,
    output logic                    flash_rd,
    output logic [TRIM_AW-1:0]      flash_addr,
    input  wire logic [TRIM_W-1:0]  flash_rdata,
    output logic                    trim_we,
    output logic [TRIM_AW-1:0]      trim_addr,
    output logic [TRIM_W-1:0]       trim_data_q,
    output logic                    boot_busy,
    output logic                    filt_zero_q,
    output logic                    sample_tick_q,
    output acr_pkg::acr_cfg_t       cfg_q
);

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic hit;
    logic wr1;
    logic wr2;
    logic wrr;

    // Only accesses to this part's target address are taken.
    assign hit = acc.valid && (acc.target[6:1] == `ACR_TGT_HI)
                 && (acc.target[0] == addr_sel);              // [RQ2]
    assign wr1 = hit && acc.write
                 && (acc.addr == `ACR_REG_CTRL1);             // [RQ1]
    assign wr2 = hit && acc.write && (acc.addr == `ACR_REG_CTRL2);
    assign wrr = hit && acc.write && (acc.addr == `ACR_REG_REF);

    // ------------------------------------------------------------------
    // Software-visible registers
    // ------------------------------------------------------------------
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl1_d;
    logic [7:0] ctrl2_q;
    logic [7:0] ctrl2_d;
    logic [7:0] ref_q;
    logic [7:0] ref_d;
    logic [7:0] rdata_d;
    logic       rvalid_d;
    logic       fzero_d;
    logic       boot_start;
    logic       boot_done;

    // A reload starts when software writes the reload bit as one.
    assign boot_start = wr2 && acc.wdata[`ACR_C2_BOOT];       // [RQ8]

    // Next values of the registers and of the read answer.
    always_comb
    begin
        ctrl1_d  = ctrl1_q;
        ctrl2_d  = ctrl2_q;
        ref_d    = ref_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        fzero_d  = 1'b0;
        if (wr1)
        begin
            ctrl1_d = acc.wdata;
        end
        if (wr2)
        begin
            ctrl2_d = acc.wdata;
        end
        // The finished copy drops the reload bit, unless a new reload
        // is written in the same cycle, which then wins.
        if (boot_done && !boot_start)
        begin
            ctrl2_d[`ACR_C2_BOOT] = 1'b0;                     // [RQ9]
        end
        if (wrr)
        begin
            ref_d = acc.wdata;                                // [RQ18]
        end
        if (hit && !acc.write)
        begin
            rvalid_d = 1'b1;
            case (acc.addr)                                   // [RQ1]
                `ACR_REG_CTRL1: rdata_d = ctrl1_q;
                `ACR_REG_CTRL2: rdata_d = ctrl2_q;
                `ACR_REG_REF:   rdata_d = ref_q;
                default:        rdata_d = 8'h00;
            endcase
            fzero_d = (acc.addr == `ACR_REG_ZERO);            // [RQ17]
        end
    end

    // Registers hold documented reset values.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl1_q     <= `ACR_CTRL1_RST;                    // [RQ3] [RQ7]
            ctrl2_q     <= `ACR_CTRL2_RST;        // [RQ11] [RQ12] [RQ13]
            ref_q       <= `ACR_REF_RST;                      // [RQ18]
            rdata_q     <= 8'h00;
            rvalid_q    <= 1'b0;
            filt_zero_q <= 1'b0;
        end
        else
        begin
            ctrl1_q     <= ctrl1_d;
            ctrl2_q     <= ctrl2_d;
            ref_q       <= ref_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
            filt_zero_q <= fzero_d;
        end
    end

    // ------------------------------------------------------------------
    // Trim reload
    // ------------------------------------------------------------------
    // Loader runs at power-up by itself and on a reload request made while it is idle.
    acr_trim_loader #(
        .TRIM_AW (TRIM_AW),
        .TRIM_W  (TRIM_W)
    ) u_loader (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .start       (boot_start),                       // [RQ8] [RQ10]
        .flash_rd    (flash_rd),
        .flash_addr  (flash_addr),
        .flash_rdata (flash_rdata),
        .trim_we     (trim_we),
        .trim_addr   (trim_addr),
        .trim_data_q (trim_data_q),
        .busy        (boot_busy),
        .done_q      (boot_done)
    );

    // ------------------------------------------------------------------
    // Active sampling configuration
    // ------------------------------------------------------------------
    logic [2:0]  act_pm_q;
    logic [2:0]  act_pm_d;
    logic [1:0]  act_dr_q;
    logic [1:0]  act_dr_d;
    logic [2:0]  act_ax_q;
    logic [2:0]  act_ax_d;
    logic        running;
    logic [31:0] period;
    acr_pkg::acr_pwr_t act_pwr;

    // Decodes the power field; the unused code counts as power-down.
    always_comb
    begin
        case (act_pm_q)
            3'h0:    act_pwr = acr_pkg::ACR_PWR_DOWN;         // [RQ3]
            3'h1:    act_pwr = acr_pkg::ACR_PWR_NORMAL;       // [RQ4]
            3'h7:    act_pwr = acr_pkg::ACR_PWR_DOWN;         // [RQ19]
            default: act_pwr = acr_pkg::ACR_PWR_LOW;          // [RQ4]
        endcase
    end

    assign running = (act_pwr != acr_pkg::ACR_PWR_DOWN);

    // Picks the sample period of the active mode and rate.
    always_comb
    begin
        case (act_pwr)
            acr_pkg::ACR_PWR_NORMAL: period = PERIODS[act_dr_q]; // [RQ5]
            acr_pkg::ACR_PWR_LOW:
                period = PERIODS[4'(act_pm_q) + 4'h2];        // [RQ4]
            default: period = 32'h0000_0002;
        endcase
    end

    // New settings are taken only at a boundary, or at once when
    // nothing is being sampled.
    always_comb
    begin
        act_pm_d = act_pm_q;
        act_dr_d = act_dr_q;
        act_ax_d = act_ax_q;
        if (sample_tick_q || !running)
        begin
            act_pm_d = ctrl1_q[`ACR_C1_PM];                   // [RQ20]
            act_dr_d = ctrl1_q[`ACR_C1_DR];
            act_ax_d = ctrl1_q[`ACR_C1_AX];
        end
    end

    // Registers the active configuration.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            act_pm_q <= 3'(`ACR_CTRL1_RST >> 5);
            act_dr_q <= 2'h0;
            act_ax_q <= 3'h7;
        end
        else
        begin
            act_pm_q <= act_pm_d;
            act_dr_q <= act_dr_d;
            act_ax_q <= act_ax_d;
        end
    end

    // Sample boundary generator.
    acr_sample_timer u_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .run     (running),
        .period  (period),
        .tick_q  (sample_tick_q)
    );

    // ------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------
    acr_pkg::acr_cfg_t cfg_d;
    logic [19:0]       odr_hz;
    logic [1:0]        hpm;
    logic              hp_on;

    // Normal-mode output rate of the active rate field.
    always_comb
    begin
        case (act_dr_q)
            2'h0:    odr_hz = 20'(`ACR_ODR0_HZ);              // [RQ5]
            2'h1:    odr_hz = 20'(`ACR_ODR1_HZ);
            2'h2:    odr_hz = 20'(`ACR_ODR2_HZ);
            default: odr_hz = 20'(`ACR_ODR3_HZ);
        endcase
    end

    assign hpm   = ctrl2_q[`ACR_C2_HPM];
    assign hp_on = ctrl2_q[`ACR_C2_FDS] | ctrl2_q[`ACR_C2_HIGHPASS_IRQ_A_ON]
                   | ctrl2_q[`ACR_C2_HIGHPASS_IRQ_B_ON];

    // Derives rates, cut-offs and filter steering for the core.
    always_comb
    begin
        cfg_d         = cfg_q;
        cfg_d.pwr     = act_pwr;
        cfg_d.axis_en = act_ax_q;                             // [RQ7]
        case (act_pwr)
            acr_pkg::ACR_PWR_NORMAL:
                cfg_d.odr_mhz = 20'(odr_hz * 20'd1000);
            acr_pkg::ACR_PWR_LOW:
                cfg_d.odr_mhz = 20'(`ACR_LP0_MHZ)
                    << (act_pm_q - 3'h2);
            default: cfg_d.odr_mhz = 20'h0_0000;
        endcase
        // The 5 Hz and 10 Hz rates are not powers of two of 0.5 Hz.
        if (act_pwr == acr_pkg::ACR_PWR_LOW && act_pm_q == 3'h5)
        begin
            cfg_d.odr_mhz = 20'(`ACR_LP3_HZ * 1000);
        end
        if (act_pwr == acr_pkg::ACR_PWR_LOW && act_pm_q == 3'h6)
        begin
            cfg_d.odr_mhz = 20'(`ACR_LP4_HZ * 1000);
        end
        case (act_dr_q)                                       // [RQ6]
            2'h0:    cfg_d.lp_cut_hz = `ACR_LPF0_HZ;
            2'h1:    cfg_d.lp_cut_hz = `ACR_LPF1_HZ;
            2'h2:    cfg_d.lp_cut_hz = `ACR_LPF2_HZ;
            default: cfg_d.lp_cut_hz = `ACR_LPF3_HZ;
        endcase
        cfg_d.hp_coeff = `ACR_HPC_BASE
            << ctrl2_q[`ACR_C2_HPCF];                         // [RQ15]
        cfg_d.hp_cut_mhz = 15'((odr_hz * 20'(`ACR_HP_MHZ_PER_HZ))
            >> ctrl2_q[`ACR_C2_HPCF]);                        // [RQ16]
        cfg_d.filt_out_sel = ctrl2_q[`ACR_C2_FDS];            // [RQ12]
        cfg_d.hp_irq_a_on  = ctrl2_q[`ACR_C2_HIGHPASS_IRQ_A_ON];          // [RQ14]
        cfg_d.hp_irq_b_on  = ctrl2_q[`ACR_C2_HIGHPASS_IRQ_B_ON];          // [RQ13]
        cfg_d.hp_ref_mode  = (hpm == 2'h1);                   // [RQ11] [RQ19]
        cfg_d.hp_ref_val   = (hp_on && hpm == 2'h1) ? ref_q
                             : 8'h00;                         // [RQ18]
    end

    // Registers the configuration outputs.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_q <= '{pwr: acr_pkg::ACR_PWR_DOWN, axis_en: 3'h7,
                       odr_mhz: 20'h0_0000, lp_cut_hz: `ACR_LPF0_HZ,
                       hp_coeff: `ACR_HPC_BASE, hp_cut_mhz: 15'h0000,
                       filt_out_sel: 1'b0, hp_irq_a_on: 1'b0,
                       hp_irq_b_on: 1'b0, hp_ref_mode: 1'b0,
                       hp_ref_val: 8'h00};
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

endmodule
`default_nettype wire

// [include/acr_defs.svh]
// Register map, field positions, reset values and timing counts for the
// accelerometer control register bank.
// Assumes a 250 MHz ref_clk; included by its bare name.
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// ----------------------------------------------------------------------
// Serial target address and register addresses (7-bit)
// ----------------------------------------------------------------------
`define ACR_TGT_HI      6'h0C
`define ACR_REG_CTRL1   7'h20
`define ACR_REG_CTRL2   7'h21
`define ACR_REG_ZERO    7'h25
`define ACR_REG_REF     7'h26

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define ACR_CTRL1_RST   8'h07
`define ACR_CTRL2_RST   8'h00
`define ACR_REF_RST     8'h00
`define ACR_C1_PM       7:5
`define ACR_C1_DR       4:3
`define ACR_C1_AX       2:0
`define ACR_C2_BOOT     7
`define ACR_C2_HPM      6:5
`define ACR_C2_FDS      4
`define ACR_C2_HIGHPASS_IRQ_B_ON    3
`define ACR_C2_HIGHPASS_IRQ_A_ON    2
`define ACR_C2_HPCF     1:0

// ----------------------------------------------------------------------
// Rates, cut-offs and sample periods in ref_clk cycles
// ----------------------------------------------------------------------
`define ACR_CLK_HZ      250000000
`define ACR_ODR0_HZ     50
`define ACR_ODR1_HZ     100
`define ACR_ODR2_HZ     400
`define ACR_ODR3_HZ     1000
`define ACR_LP0_MHZ     500
`define ACR_LP1_HZ      1
`define ACR_LP2_HZ      2
`define ACR_LP3_HZ      5
`define ACR_LP4_HZ      10
`define ACR_LPF0_HZ     10'd37
`define ACR_LPF1_HZ     10'd74
`define ACR_LPF2_HZ     10'd292
`define ACR_LPF3_HZ     10'd780
`define ACR_HPC_BASE    7'd8
`define ACR_HP_MHZ_PER_HZ 20
`define ACR_CYC_ODR0 (`ACR_CLK_HZ / `ACR_ODR0_HZ)
`define ACR_CYC_ODR1 (`ACR_CLK_HZ / `ACR_ODR1_HZ)
`define ACR_CYC_ODR2 (`ACR_CLK_HZ / `ACR_ODR2_HZ)
`define ACR_CYC_ODR3 (`ACR_CLK_HZ / `ACR_ODR3_HZ)
`define ACR_CYC_LP0  ((`ACR_CLK_HZ / `ACR_LP0_MHZ) * 1000)
`define ACR_CYC_LP1  (`ACR_CLK_HZ / `ACR_LP1_HZ)
`define ACR_CYC_LP2  (`ACR_CLK_HZ / `ACR_LP2_HZ)
`define ACR_CYC_LP3  (`ACR_CLK_HZ / `ACR_LP3_HZ)
`define ACR_CYC_LP4  (`ACR_CLK_HZ / `ACR_LP4_HZ)

`endif

// [include/acr_pkg.sv]
// Types shared by the accelerometer control register bank.
// Assumes nothing of its surroundings.
package acr_pkg;

    // Decoded power state, one-hot.
    typedef enum logic [2:0] {
        ACR_PWR_DOWN   = 3'b001,
        ACR_PWR_NORMAL = 3'b010,
        ACR_PWR_LOW    = 3'b100
    } acr_pwr_t;

    // Trim loader states, one-hot.
    typedef enum logic [3:0] {
        ACR_LD_IDLE = 4'b0001,
        ACR_LD_READ = 4'b0010,
        ACR_LD_CAPT = 4'b0100,
        ACR_LD_WRIT = 4'b1000
    } acr_ld_t;

    // One register access decoded from the serial interface.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [6:0] target;
        logic [6:0] addr;
        logic [7:0] wdata;
    } acr_access_t;

    // Configuration the block drives into the sensing core.
    typedef struct packed {
        acr_pwr_t    pwr;
        logic [2:0]  axis_en;
        logic [19:0] odr_mhz;
        logic [9:0]  lp_cut_hz;
        logic [6:0]  hp_coeff;
        logic [14:0] hp_cut_mhz;
        logic        filt_out_sel;
        logic        hp_irq_a_on;
        logic        hp_irq_b_on;
        logic        hp_ref_mode;
        logic [7:0]  hp_ref_val;
    } acr_cfg_t;

endpackage

// [logic/acr_sample_timer.sv]
// Sample boundary timer: pulses once every period cycles while running.
// Assumes period is at least 2 and stays stable between boundaries.
`timescale 1ns/10ps
`default_nettype none
module acr_sample_timer
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [31:0] period,
    output logic             tick_q
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        tick_d;

    // Counts up to period-1, then wraps with a one-cycle tick.
    always_comb
    begin
        cnt_d  = cnt_q + 32'h0000_0001;
        tick_d = 1'b0;
        if (!run)
        begin
            cnt_d = 32'h0000_0000;
        end
        else if (cnt_q >= period - 32'h0000_0001)
        begin
            cnt_d  = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end

    // Registers the counter and the tick.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

endmodule
`default_nettype wire

// [logic/acr_trim_loader.sv]
// Copies factory trim words from flash into the trimming registers.
// Assumes flash returns read data one cycle after flash_rd.
`timescale 1ns/10ps
`default_nettype none
module acr_trim_loader
#(
    parameter int TRIM_AW = 3,
    parameter int TRIM_W  = 8
)
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               start,
    output logic                    flash_rd,
    output logic [TRIM_AW-1:0]      flash_addr,
    input  wire logic [TRIM_W-1:0]  flash_rdata,
    output logic                    trim_we,
    output logic [TRIM_AW-1:0]      trim_addr,
    output logic [TRIM_W-1:0]       trim_data_q,
    output logic                    busy,
    output logic                    done_q
);

    localparam logic [TRIM_AW-1:0] LAST = '1;

    acr_pkg::acr_ld_t    st_q;
    acr_pkg::acr_ld_t    st_d;
    logic [TRIM_AW-1:0]  idx_q;
    logic [TRIM_AW-1:0]  idx_d;
    logic [TRIM_W-1:0]   dat_d;
    logic                pwrup_q;
    logic                done_d;

    // Walks every trim word: read, capture, write; a power-up load
    // starts on its own once reset is released.
    always_comb
    begin
        st_d   = st_q;
        idx_d  = idx_q;
        dat_d  = trim_data_q;
        done_d = 1'b0;
        case (st_q)
            acr_pkg::ACR_LD_IDLE:
            begin
                if (start || pwrup_q)
                begin
                    st_d  = acr_pkg::ACR_LD_READ;
                    idx_d = '0;
                end
            end
            acr_pkg::ACR_LD_READ: st_d = acr_pkg::ACR_LD_CAPT;
            acr_pkg::ACR_LD_CAPT:
            begin
                dat_d = flash_rdata;
                st_d  = acr_pkg::ACR_LD_WRIT;
            end
            acr_pkg::ACR_LD_WRIT:
            begin
                if (idx_q == LAST)
                begin
                    st_d   = acr_pkg::ACR_LD_IDLE;
                    done_d = 1'b1;
                end
                else
                begin
                    st_d  = acr_pkg::ACR_LD_READ;
                    idx_d = idx_q + 1'b1;
                end
            end
            default: st_d = acr_pkg::ACR_LD_IDLE;
        endcase
    end

    // Registers the loader state.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q        <= acr_pkg::ACR_LD_IDLE;
            idx_q       <= '0;
            trim_data_q <= '0;
            pwrup_q     <= 1'b1;
            done_q      <= 1'b0;
        end
        else
        begin
            st_q        <= st_d;
            idx_q       <= idx_d;
            trim_data_q <= dat_d;
            pwrup_q     <= 1'b0;
            done_q      <= done_d;
        end
    end

    // Flash and trim strobes follow the state directly.
    assign flash_rd   = (st_q == acr_pkg::ACR_LD_READ);
    assign flash_addr = idx_q;
    assign trim_we    = (st_q == acr_pkg::ACR_LD_WRIT);
    assign trim_addr  = idx_q;
    assign busy       = (st_q != acr_pkg::ACR_LD_IDLE);

endmodule
`default_nettype wire

// [tb/acr_accel_ctrl_sva.sv]
// Checker for the control register bank, bound to its top module.
// Assumes acr_pkg is compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module acr_accel_ctrl_sva
#(
    parameter int TRIM_AW = 3,
    parameter int TRIM_W  = 8
)
(
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire acr_pkg::acr_access_t acc,
    input wire logic                 addr_sel,
    input wire logic [7:0]           rdata_q,
    input wire logic                 rvalid_q,
    input wire logic                 flash_rd,
    input wire logic [TRIM_AW-1:0]   flash_addr,
    input wire logic [TRIM_W-1:0]    flash_rdata,
    input wire logic                 trim_we,
    input wire logic [TRIM_AW-1:0]   trim_addr,
    input wire logic [TRIM_W-1:0]    trim_data_q,
    input wire logic                 boot_busy,
    input wire logic                 filt_zero_q,
    input wire acr_pkg::acr_cfg_t    cfg_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic take_rd;

    // A read aimed at this device's target address.
    assign take_rd = acc.valid && !acc.write
                     && acc.target == {6'h0C, addr_sel};

    a_read_answer: assert property (take_rd |=> rvalid_q)
        else $error("read not answered");
    a_bad_target: assert property (acc.valid && acc.target != {6'h0C, addr_sel}
        |=> !rvalid_q) else $error("foreign target answered");
    a_zero_read: assert property (take_rd && acc.addr == 7'h25
        |=> filt_zero_q && rdata_q == 8'h00) else $error("zero read");
    a_zero_cause: assert property (filt_zero_q
        |-> $past(take_rd && acc.addr == 7'h25)) else $error("stray zero");
    a_trim_copy: assert property (flash_rd |-> ##2 trim_we
        && trim_addr == $past(flash_addr, 2)
        && trim_data_q == $past(flash_rdata)) else $error("trim copy");
    a_load_busy: assert property (flash_rd |-> boot_busy)
        else $error("flash read while idle");
    a_down_still: assert property (cfg_q.pwr == acr_pkg::ACR_PWR_DOWN
        |-> cfg_q.odr_mhz == 20'h0) else $error("rate in down");
    a_coeff_set: assert property (cfg_q.hp_coeff inside
        {7'h08, 7'h10, 7'h20, 7'h40}) else $error("coefficient");
    a_lp_cut: assert property (cfg_q.lp_cut_hz inside
        {10'h025, 10'h04A, 10'h124, 10'h30C}) else $error("low-pass");
    a_ref_gate: assert property (!cfg_q.hp_ref_mode
        |-> cfg_q.hp_ref_val == 8'h00) else $error("reference leak");

    c_zero: cover property (take_rd && acc.addr == 7'h25);
    c_trim: cover property (trim_we);
    c_low: cover property (cfg_q.pwr == acr_pkg::ACR_PWR_LOW);
endmodule
bind acr_accel_ctrl acr_accel_ctrl_sva #(.TRIM_AW(TRIM_AW), .TRIM_W(TRIM_W))
    i_acr_accel_ctrl_sva (.*);
`default_nettype wire

// [tb/acr_flash_model.sv]
// Trim flash model: answers a read one cycle after the strobe.
// Assumes three address bits and byte-wide words.
`timescale 1ns/10ps
`default_nettype none
module acr_flash_model
(
    input wire logic       ref_clk,
    input wire logic       flash_rd,
    input wire logic [2:0] flash_addr,
    output logic [7:0]     flash_rdata
);
    // Outside a read the bus is scrambled so stale data is not reused.
    always @(posedge ref_clk)
        flash_rdata <= flash_rd ? 8'hA0 ^ 8'(flash_addr)
                                : ~flash_rdata;
endmodule
`default_nettype wire

// [tb/tb_acr_accel_ctrl.sv]
// Testbench for the control register bank.
// Assumes acr_pkg, the design, the checker and the flash model compiled.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_acr_accel_ctrl;
    localparam logic [8:0][31:0] PER = {32'd20, 32'd18, 32'd16, 32'd14,
        32'd12, 32'd10, 32'd8, 32'd6, 32'd4};
    localparam logic [10:0][7:0] CODE = {8'h17, 8'hEF, 8'hC5, 8'hBD,
        8'h95, 8'h6D, 8'h45, 8'h3E, 8'h36, 8'h2E, 8'h26};
    localparam logic [10:0][19:0] ODR_E = {20'h0, 20'h0, 20'h02710,
        20'h01388, 20'h007D0, 20'h003E8, 20'h001F4, 20'hF4240,
        20'h61A80, 20'h186A0, 20'h0C350};
    localparam logic [3:0][9:0] LP_E = {10'h30C, 10'h124, 10'h04A, 10'h025};
    localparam logic [3:0][14:0] HP_E = {15'h4E20, 15'h1F40, 15'h07D0,
        15'h03E8};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic addr_sel = 1'b0;
    acr_pkg::acr_access_t acc = '0;
    logic [7:0] rdata_q, flash_rdata, trim_data_q, v;
    logic rvalid_q, flash_rd, trim_we, boot_busy, filt_zero_q, sample_tick_q;
    logic [2:0] flash_addr, trim_addr;
    acr_pkg::acr_cfg_t cfg_q;
    acr_pkg::acr_pwr_t pe;
    int failures = 0;
    int checked = 0;
    int trims = 0;

    acr_accel_ctrl #(.PERIODS(PER)) i_acr_accel_ctrl (.ref_clk(ref_clk),
        .rst(rst), .acc(acc), .addr_sel(addr_sel), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .trim_we(trim_we),
        .trim_addr(trim_addr), .trim_data_q(trim_data_q),
        .boot_busy(boot_busy), .filt_zero_q(filt_zero_q),
        .sample_tick_q(sample_tick_q), .cfg_q(cfg_q));
    acr_flash_model i_acr_flash_model (.ref_clk(ref_clk),
        .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata));

    // Clock and a count of trim words written.
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (trim_we === 1'b1) trims++;

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One access; bad aims it at the other target address.
    task automatic acc_op(input logic w, input logic [6:0] a,
        input logic [7:0] d, input logic bad);
        @(posedge ref_clk);
        acc <= '{1'b1, w, {6'h0C, addr_sel ^ bad}, a, d};
        @(posedge ref_clk);
        acc <= '0;
        #1;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        acc_op(1'b0, a, 8'h00, 1'b0);
        `CHK(rvalid_q, 1'b1)
        `CHK(rdata_q, e)
    endtask

    // Waits for an idle loader and the given rate, bounded.
    task automatic settle(input logic [19:0] e);
        int n;
        n = 0;
        do begin @(posedge ref_clk); #1; n++; end
        while ((boot_busy !== 1'b0 || cfg_q.odr_mhz !== e) && n < 200);
        if (n == 200)
        begin
            failures++;
            wrap_up();
        end
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // Measures the spacing of sample ticks.
    task automatic gap(input int e);
        int n;
        n = 0;
        while (sample_tick_q !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        n = 0;
        do begin @(posedge ref_clk); #1; n++; end
        while (sample_tick_q !== 1'b1 && n < 50);
        `CHK(n, e)
    endtask

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        settle(20'h0);
        `CHK(trims, 8)
        rd_chk(7'h20, 8'h07);
        rd_chk(7'h21, 8'h00);
        `CHK(cfg_q.pwr, acr_pkg::ACR_PWR_DOWN)
        rd_chk(7'h30, 8'h00);
        acc_op(1'b0, 7'h20, 8'h00, 1'b1);
        `CHK(rvalid_q, 1'b0)
        @(posedge ref_clk) addr_sel <= 1'b1;
        rd_chk(7'h20, 8'h07);
        for (int k = 0; k < 11; k++)
        begin
            v = CODE[k];
            pe = k < 4 ? acr_pkg::ACR_PWR_NORMAL : k < 9 ?
                acr_pkg::ACR_PWR_LOW : acr_pkg::ACR_PWR_DOWN;
            acc_op(1'b1, 7'h20, v, 1'b0);
            if (k > 0 && k < 10) `CHK(cfg_q.odr_mhz, ODR_E[k-1])
            settle(ODR_E[k]);
            rd_chk(7'h20, v);
            `CHK(cfg_q.pwr, pe)
            `CHK(cfg_q.lp_cut_hz, LP_E[v[4:3]])
            `CHK(cfg_q.hp_cut_mhz, HP_E[v[4:3]])
            `CHK(cfg_q.axis_en, v[2:0])
            if (k < 9) gap(k < 4 ? 4 + 2 * v[4:3] : 8 + 2 * v[7:5]);
        end
        acc_op(1'b1, 7'h26, 8'h5A, 1'b0);
        for (int j = 0; j < 4; j++)
        begin
            v = {1'b0, j[1:0], j[0], j[1], ~j[0], j[1:0]};
            acc_op(1'b1, 7'h21, v, 1'b0);
            rd_chk(7'h21, v);
            `CHK(cfg_q.hp_coeff, 7'h08 << j)
            `CHK(cfg_q.hp_cut_mhz, 15'h1F40 >> j)
            `CHK({cfg_q.filt_out_sel, cfg_q.hp_irq_a_on, cfg_q.hp_irq_b_on},
                {j[0], ~j[0], j[1]})
            `CHK(cfg_q.hp_ref_val, j == 1 ? 8'h5A : 8'h00)
        end
        trims = 0;
        acc_op(1'b1, 7'h21, 8'h80, 1'b0);
        rd_chk(7'h21, 8'h80);
        settle(20'h0);
        `CHK(trims, 8)
        rd_chk(7'h21, 8'h00);
        rd_chk(7'h25, 8'h00);
        `CHK(filt_zero_q, 1'b1)
        wrap_up();
    end
endmodule
`default_nettype wire
